// ---- src/cdt_pkg.sv ----
// Purpose: Shared constants and types for the instruction decode and timing unit
// Assumes: 14-bit instruction words, four clock phases per instruction cycle
// Notes: Field positions follow the instruction word layout
package cdt_pkg;

    localparam int INSTR_W = 14;
    localparam int FILE_ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int LIT_W = 11;
    localparam int BIT_POS_W = 3;
    localparam int PHASES = 4;
    localparam int PHASE_W = 2;
    localparam int CLK_PERIOD_NS = 5;

    // Field positions within the instruction word
    localparam int GROUP_MSB = 13;
    localparam int GROUP_LSB = 12;
    localparam int SUBOP_MSB = 11;
    localparam int SUBOP_LSB = 8;
    localparam int DEST_POS = 7;
    localparam int BIT_POS_LSB = 7;
    localparam int PTR_NUM_POS = 2;
    localparam int PTR_MODE_LSB = 0;

    // Indirect window locations in every bank
    localparam logic [FILE_ADDR_W-1:0] WINDOW0_ADDR = 7'h00;
    localparam logic [FILE_ADDR_W-1:0] WINDOW1_ADDR = 7'h01;

    // Inherent control encodings
    localparam logic [7:0] ENC_SUB_EXIT = 8'h08;
    localparam logic [7:0] ENC_INT_EXIT = 8'h09;
    localparam logic [7:0] ENC_SUB_ENTRY_BY_ACC = 8'h0a;
    localparam logic [7:0] ENC_BRANCH_BY_ACC = 8'h0b;

    // Skip-on-zero tests on the value read before modification
    localparam logic [DATA_W-1:0] DEC_HITS_ZERO = 8'h01;
    localparam logic [DATA_W-1:0] INC_HITS_ZERO = 8'hff;

    typedef enum logic [1:0] {
        GRP_BYTE,
        GRP_BIT,
        GRP_LITCTL
    } cdt_group_t;

    typedef enum logic [4:0] {
        OP_INHERENT,
        OP_BYTE_ALU,
        OP_STORE_ACC,
        OP_CLEAR_FILE,
        OP_CLEAR_ACC,
        OP_DEC_SKIP_ZERO,
        OP_INC_SKIP_ZERO,
        OP_BIT_WRITE,
        OP_SKIP_IF_BIT_CLEAR,
        OP_SKIP_IF_BIT_SET,
        OP_LITERAL,
        OP_BANK_SELECT,
        OP_PAGE_SELECT,
        OP_IND_READ,
        OP_IND_WRITE,
        OP_SUB_ENTRY,
        OP_SUB_ENTRY_BY_ACC,
        OP_SUB_EXIT,
        OP_SUB_EXIT_LIT,
        OP_INT_EXIT,
        OP_ABSOLUTE_JUMP,
        OP_RELATIVE_BRANCH,
        OP_BRANCH_BY_ACC
    } cdt_op_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_EXEC,
        SEQ_EXTRA,
        SEQ_FLUSH
    } cdt_seq_t;

    typedef struct packed {
        cdt_group_t group;
        cdt_op_t op;
        logic [FILE_ADDR_W-1:0] file_addr;
        logic [BIT_POS_W-1:0] bit_pos;
        logic [LIT_W-1:0] lit;
        logic dest;
        logic ptr_num;
        logic [1:0] ptr_mode;
        logic uses_file;
        logic writes_file;
        logic writes_acc;
    } cdt_dec_t;

    typedef struct packed {
        cdt_seq_t st;
        cdt_dec_t dec;
        logic [DATA_W-1:0] rdata;
        logic taken;
        logic [1:0] cycles;
    } cdt_core_state_t;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
    } cdt_phase_state_t;

endpackage

// ---- src/cdt_phase_gen.sv ----
// Purpose: Phase counter splitting each instruction cycle into clock phases
// Assumes: Free running from reset release
// Notes: o_last marks the final phase of every instruction cycle
`timescale 1ns/1ps
module cdt_phase_gen #(
    parameter int PHASES = cdt_pkg::PHASES
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    output logic [cdt_pkg::PHASE_W-1:0] o_phase,
    output logic o_last
);

    localparam logic [cdt_pkg::PHASE_W-1:0] LAST_PHASE = cdt_pkg::PHASE_W'(PHASES - 1);

    cdt_pkg::cdt_phase_state_t s_reg;
    cdt_pkg::cdt_phase_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (s_reg.phase == LAST_PHASE) begin
            s_next.phase = '0;
        end else begin
            s_next.phase = s_reg.phase + cdt_pkg::PHASE_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_phase = s_reg.phase;
    assign o_last = (s_reg.phase == LAST_PHASE);

endmodule

// ---- src/cdt_decode_timing.sv ----
// Purpose: Instruction decode and cycle sequencing for the 8-bit core
// Assumes: Program memory and file data come from logic on i_clk
// Notes: Phase 1 reads the file, phase 3 writes the result
`timescale 1ns/1ps
module cdt_decode_timing (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [cdt_pkg::INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [cdt_pkg::DATA_W-1:0] i_file_rdata,
    input wire logic [1:0] i_ptr_in_prog,
    output logic o_fetch,
    output logic [cdt_pkg::PHASE_W-1:0] o_phase,
    output cdt_pkg::cdt_dec_t o_dec,
    output logic o_busy,
    output logic o_file_rd,
    output logic o_file_wr,
    output logic o_acc_wr,
    output logic o_pc_redirect,
    output logic o_extra_cycle,
    output logic o_nop_cycle,
    output logic [1:0] o_cycles_used
);

    function automatic cdt_pkg::cdt_dec_t cdt_decode(input logic [cdt_pkg::INSTR_W-1:0] w);
        cdt_pkg::cdt_dec_t d;
        d = '0;
        // Operand fields sit at fixed places, no extension words
        d.file_addr = w[cdt_pkg::FILE_ADDR_W-1:0];
        d.bit_pos = w[cdt_pkg::BIT_POS_LSB +: cdt_pkg::BIT_POS_W];
        d.lit = w[cdt_pkg::LIT_W-1:0];
        d.dest = w[cdt_pkg::DEST_POS];
        d.ptr_num = w[cdt_pkg::PTR_NUM_POS];
        d.ptr_mode = w[cdt_pkg::PTR_MODE_LSB +: 2];
        d.op = cdt_pkg::OP_INHERENT;
        d.group = cdt_pkg::GRP_LITCTL;
        unique case (w[cdt_pkg::GROUP_MSB:cdt_pkg::GROUP_LSB])
            2'b00: begin
                d.group = cdt_pkg::GRP_BYTE;
                d.uses_file = 1'b1;
                d.op = cdt_pkg::OP_BYTE_ALU;
                unique case (w[cdt_pkg::SUBOP_MSB:cdt_pkg::SUBOP_LSB])
                    4'h0: begin
                        if (w[cdt_pkg::DEST_POS]) begin
                            d.op = cdt_pkg::OP_STORE_ACC;
                        end else begin
                            d.uses_file = 1'b0;
                            d.group = cdt_pkg::GRP_LITCTL;
                            if (w[7:5] == 3'b001) begin
                                d.op = cdt_pkg::OP_BANK_SELECT;
                            end else if (w[7:4] == 4'h1) begin
                                d.op = w[3] ? cdt_pkg::OP_IND_WRITE : cdt_pkg::OP_IND_READ;
                            end else if (w[7:0] == cdt_pkg::ENC_SUB_EXIT) begin
                                d.op = cdt_pkg::OP_SUB_EXIT;
                            end else if (w[7:0] == cdt_pkg::ENC_INT_EXIT) begin
                                d.op = cdt_pkg::OP_INT_EXIT;
                            end else if (w[7:0] == cdt_pkg::ENC_SUB_ENTRY_BY_ACC) begin
                                d.op = cdt_pkg::OP_SUB_ENTRY_BY_ACC;
                            end else if (w[7:0] == cdt_pkg::ENC_BRANCH_BY_ACC) begin
                                d.op = cdt_pkg::OP_BRANCH_BY_ACC;
                            end else begin
                                d.op = cdt_pkg::OP_INHERENT;
                            end
                        end
                    end
                    4'h1: begin
                        if (w[cdt_pkg::DEST_POS]) begin
                            d.op = cdt_pkg::OP_CLEAR_FILE;
                        end else begin
                            // Low two bits are don't-care, never looked at
                            d.op = cdt_pkg::OP_CLEAR_ACC;
                            d.uses_file = 1'b0;
                        end
                    end
                    4'hb: d.op = cdt_pkg::OP_DEC_SKIP_ZERO;
                    4'hf: d.op = cdt_pkg::OP_INC_SKIP_ZERO;
                    default: d.op = cdt_pkg::OP_BYTE_ALU;
                endcase
            end
            2'b01: begin
                d.group = cdt_pkg::GRP_BIT;
                d.uses_file = 1'b1;
                if (!w[11]) begin
                    d.op = cdt_pkg::OP_BIT_WRITE;
                end else if (w[10]) begin
                    d.op = cdt_pkg::OP_SKIP_IF_BIT_SET;
                end else begin
                    d.op = cdt_pkg::OP_SKIP_IF_BIT_CLEAR;
                end
            end
            2'b10: begin
                d.op = w[11] ? cdt_pkg::OP_ABSOLUTE_JUMP : cdt_pkg::OP_SUB_ENTRY;
            end
            2'b11: begin
                unique case (w[cdt_pkg::SUBOP_MSB:cdt_pkg::SUBOP_LSB])
                    4'h5, 4'h6, 4'h7, 4'hb, 4'hd: begin
                        d.group = cdt_pkg::GRP_BYTE;
                        d.uses_file = 1'b1;
                        d.op = cdt_pkg::OP_BYTE_ALU;
                    end
                    4'h2, 4'h3: d.op = cdt_pkg::OP_RELATIVE_BRANCH;
                    4'h4: d.op = cdt_pkg::OP_SUB_EXIT_LIT;
                    4'h1: d.op = w[7] ? cdt_pkg::OP_PAGE_SELECT : cdt_pkg::OP_LITERAL;
                    default: d.op = cdt_pkg::OP_LITERAL;
                endcase
            end
        endcase
        // Where the result lands
        if (d.op == cdt_pkg::OP_STORE_ACC || d.op == cdt_pkg::OP_CLEAR_FILE ||
            d.op == cdt_pkg::OP_BIT_WRITE) begin
            d.writes_file = 1'b1;
        end else if (d.group == cdt_pkg::GRP_BYTE) begin
            d.writes_file = d.dest;
            d.writes_acc = !d.dest;
        end else if (d.op == cdt_pkg::OP_CLEAR_ACC || d.op == cdt_pkg::OP_LITERAL ||
                     d.op == cdt_pkg::OP_SUB_EXIT_LIT) begin
            d.writes_acc = 1'b1;
        end
        return d;
    endfunction

    cdt_pkg::cdt_core_state_t s_reg;
    cdt_pkg::cdt_core_state_t s_next;
    logic [cdt_pkg::PHASE_W-1:0] phase;
    logic last;
    logic fetch_now;
    logic fixed_two;
    logic skip_taken;
    logic taken_now;
    logic ind_ref;
    logic ind_sel;
    logic need_extra;

    cdt_phase_gen #(
        .PHASES(cdt_pkg::PHASES)
    ) u_phase (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .o_phase(phase),
        .o_last(last)
    );

    always_comb begin
        fixed_two = 1'b0;
        skip_taken = 1'b0;
        unique case (s_reg.dec.op)
            cdt_pkg::OP_SUB_ENTRY, cdt_pkg::OP_SUB_ENTRY_BY_ACC: fixed_two = 1'b1;
            cdt_pkg::OP_SUB_EXIT, cdt_pkg::OP_SUB_EXIT_LIT, cdt_pkg::OP_INT_EXIT: fixed_two = 1'b1;
            cdt_pkg::OP_ABSOLUTE_JUMP, cdt_pkg::OP_RELATIVE_BRANCH,
            cdt_pkg::OP_BRANCH_BY_ACC: fixed_two = 1'b1;
            cdt_pkg::OP_SKIP_IF_BIT_CLEAR: skip_taken = !s_reg.rdata[s_reg.dec.bit_pos];
            cdt_pkg::OP_SKIP_IF_BIT_SET: skip_taken = s_reg.rdata[s_reg.dec.bit_pos];
            cdt_pkg::OP_DEC_SKIP_ZERO: skip_taken = (s_reg.rdata == cdt_pkg::DEC_HITS_ZERO);
            cdt_pkg::OP_INC_SKIP_ZERO: skip_taken = (s_reg.rdata == cdt_pkg::INC_HITS_ZERO);
            default: begin
                fixed_two = 1'b0;
                skip_taken = 1'b0;
            end
        endcase
        taken_now = fixed_two || skip_taken;
        // Indirect window or implicit pointer access
        ind_ref = (s_reg.dec.uses_file && (s_reg.dec.file_addr == cdt_pkg::WINDOW0_ADDR ||
                   s_reg.dec.file_addr == cdt_pkg::WINDOW1_ADDR)) ||
                  s_reg.dec.op == cdt_pkg::OP_IND_READ || s_reg.dec.op == cdt_pkg::OP_IND_WRITE;
        ind_sel = (s_reg.dec.op == cdt_pkg::OP_IND_READ || s_reg.dec.op == cdt_pkg::OP_IND_WRITE) ?
                  s_reg.dec.ptr_num : s_reg.dec.file_addr[0];
        need_extra = ind_ref && i_ptr_in_prog[ind_sel];
    end

    always_comb begin
        s_next = s_reg;
        fetch_now = 1'b0;
        // Capture read data one phase after the read strobe
        if (s_reg.st == cdt_pkg::SEQ_EXEC && phase == cdt_pkg::PHASE_W'(2)) begin
            s_next.rdata = i_file_rdata;
        end
        if (last) begin
            unique case (s_reg.st)
                cdt_pkg::SEQ_IDLE: fetch_now = 1'b1;
                cdt_pkg::SEQ_EXEC: begin
                    s_next.taken = taken_now;
                    if (need_extra) begin
                        s_next.st = cdt_pkg::SEQ_EXTRA;
                        s_next.cycles = s_reg.cycles + 2'h1;
                    end else if (taken_now) begin
                        s_next.st = cdt_pkg::SEQ_FLUSH;
                        s_next.cycles = s_reg.cycles + 2'h1;
                    end else begin
                        fetch_now = 1'b1;
                    end
                end
                cdt_pkg::SEQ_EXTRA: begin
                    if (s_reg.taken) begin
                        s_next.st = cdt_pkg::SEQ_FLUSH;
                        s_next.cycles = s_reg.cycles + 2'h1;
                    end else begin
                        fetch_now = 1'b1;
                    end
                end
                cdt_pkg::SEQ_FLUSH: fetch_now = 1'b1;
            endcase
            if (fetch_now) begin
                s_next.taken = 1'b0;
                if (i_instr_valid) begin
                    s_next.st = cdt_pkg::SEQ_EXEC;
                    s_next.dec = cdt_decode(i_instr);
                    s_next.cycles = 2'h1;
                end else begin
                    s_next.st = cdt_pkg::SEQ_IDLE;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_fetch = fetch_now;
    assign o_phase = phase;
    assign o_dec = s_reg.dec;
    assign o_busy = (s_reg.st != cdt_pkg::SEQ_IDLE);
    // Every file operand is read, even when only written
    assign o_file_rd = (s_reg.st == cdt_pkg::SEQ_EXEC) && (phase == cdt_pkg::PHASE_W'(1)) &&
                       s_reg.dec.uses_file;
    assign o_file_wr = (s_reg.st == cdt_pkg::SEQ_EXEC) && last && s_reg.dec.writes_file;
    assign o_acc_wr = (s_reg.st == cdt_pkg::SEQ_EXEC) && last && s_reg.dec.writes_acc;
    assign o_pc_redirect = (s_reg.st == cdt_pkg::SEQ_EXEC) && last && taken_now;
    assign o_extra_cycle = (s_reg.st == cdt_pkg::SEQ_EXTRA);
    assign o_nop_cycle = (s_reg.st == cdt_pkg::SEQ_FLUSH);
    assign o_cycles_used = s_reg.cycles;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    logic exec_end;
    logic is_entry;
    logic is_exit;
    logic is_jump;
    assign exec_end = (s_reg.st == cdt_pkg::SEQ_EXEC) && last;
    assign is_entry = (s_reg.dec.op == cdt_pkg::OP_SUB_ENTRY) || (s_reg.dec.op == cdt_pkg::OP_SUB_ENTRY_BY_ACC);
    assign is_exit = (s_reg.dec.op == cdt_pkg::OP_SUB_EXIT) || (s_reg.dec.op == cdt_pkg::OP_SUB_EXIT_LIT) ||
                     (s_reg.dec.op == cdt_pkg::OP_INT_EXIT);
    assign is_jump = (s_reg.dec.op == cdt_pkg::OP_ABSOLUTE_JUMP) ||
                     (s_reg.dec.op == cdt_pkg::OP_RELATIVE_BRANCH) ||
                     (s_reg.dec.op == cdt_pkg::OP_BRANCH_BY_ACC);

    property p_four_phase;
        (phase == 2'h0) |=> (phase == 2'h1) ##1 (phase == 2'h2) ##1 (phase == 2'h3) ##1 (phase == 2'h0);
    endproperty
    a_four_phase: assert property (p_four_phase) else $error("instruction cycle not four clocks");

    property p_fetch_spacing;
        o_fetch |=> !o_fetch [*3];
    endproperty
    a_fetch_spacing: assert property (p_fetch_spacing) else $error("fetch closer than one cycle");

    property p_single;
        exec_end && !need_extra && !taken_now |-> o_fetch;
    endproperty
    a_single: assert property (p_single) else $error("plain instruction took more than one cycle");

    property p_entry_two;
        exec_end && is_entry && !need_extra |=> o_nop_cycle [*4] ##1 !o_nop_cycle;
    endproperty
    a_entry_two: assert property (p_entry_two) else $error("subroutine entry not two cycles");

    property p_exit_two;
        exec_end && is_exit && !need_extra |=> (o_nop_cycle && o_cycles_used == 2'h2) [*4];
    endproperty
    a_exit_two: assert property (p_exit_two) else $error("return not two cycles");

    property p_branch_two;
        exec_end && (is_jump || skip_taken) && !need_extra |-> o_pc_redirect ##1 o_nop_cycle [*4] ##1 !o_nop_cycle;
    endproperty
    a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

    property p_extra;
        exec_end && need_extra |=> (o_extra_cycle && !o_file_wr) [*4];
    endproperty
    a_extra: assert property (p_extra) else $error("indirect program access lacks extra cycle");

    property p_rmw;
        o_file_wr |-> $past(o_file_rd, 2);
    endproperty
    a_rmw: assert property (p_rmw) else $error("file write without prior read");

    property p_read_always;
        (s_reg.st == cdt_pkg::SEQ_EXEC) && (phase == 2'h0) && s_reg.dec.writes_file |=> o_file_rd;
    endproperty
    a_read_always: assert property (p_read_always) else $error("written file not read first");

    property p_dest;
        (o_file_wr || o_acc_wr) && s_reg.dec.group == cdt_pkg::GRP_BYTE &&
        s_reg.dec.op != cdt_pkg::OP_STORE_ACC && s_reg.dec.op != cdt_pkg::OP_CLEAR_FILE |->
        (o_file_wr == s_reg.dec.dest) && (o_acc_wr == !s_reg.dec.dest);
    endproperty
    a_dest: assert property (p_dest) else $error("result steered against destination bit");

    property p_nop_quiet;
        o_nop_cycle |-> !o_file_rd && !o_file_wr && !o_acc_wr && !o_pc_redirect;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("second cycle not idle");

    property p_read_phase;
        o_file_rd |-> (phase == 2'h1) ##2 (o_file_wr == s_reg.dec.writes_file);
    endproperty
    a_read_phase: assert property (p_read_phase) else $error("file read outside its phase");

    property p_extra_nop;
        o_extra_cycle && last && s_reg.taken |=> o_nop_cycle && (o_cycles_used == 2'h3);
    endproperty
    a_extra_nop: assert property (p_extra_nop) else $error("indirect skip not three cycles");

    property p_take;
        o_fetch && i_instr_valid |=> o_busy && (phase == 2'h0) && (o_cycles_used == 2'h1);
    endproperty
    a_take: assert property (p_take) else $error("fetched word not started");

endmodule

// ---- dv/cdt_prog_mem.sv ----
// Purpose: Program memory and file data source facing the decoder
// Assumes: Bench sets the word; the decoder takes it while o_fetch is high
// Notes: Outside its slot each bus shows a pattern that changes every clock
`timescale 1ns/1ps
module cdt_prog_mem (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_fetch,
    input wire logic i_file_rd,
    input wire logic [13:0] i_word,
    input wire logic [7:0] i_data,
    output logic [13:0] o_instr,
    output logic [7:0] o_file_rdata
);
    logic rd_d;
    logic [13:0] junk;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_d <= 1'b0;
            junk <= 14'h2aaa;
        end else begin
            rd_d <= i_file_rd;
            junk <= ~junk;
        end
    end
    // Whole word only in the fetch slot
    assign o_instr = i_fetch ? i_word : junk;
    // Data valid only in the clock after the read strobe
    assign o_file_rdata = rd_d ? i_data : (junk[7:0] ^ i_data);
endmodule

// ---- dv/cdt_decode_timing_test.sv ----
// Purpose: Self-checking bench for instruction decode and cycle timing
// Assumes: One word per exec call, valid dropped after the take
// Notes: Strobes are sampled on the falling edge
`timescale 1ns/1ps
module cdt_decode_timing_test;
    logic i_clk, i_rstn, pm_valid;
    logic [13:0] pm_word, instr;
    logic [7:0] pm_data, rdata;
    logic [1:0] ptr_prog, o_phase, o_cycles_used;
    logic o_fetch, o_busy, o_file_rd, o_file_wr, o_acc_wr, o_pc_redirect, o_extra_cycle, o_nop_cycle;
    cdt_pkg::cdt_dec_t o_dec, saved;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    cdt_prog_mem pm (.i_clk(i_clk), .i_rstn(i_rstn), .i_fetch(o_fetch), .i_file_rd(o_file_rd),
        .i_word(pm_word), .i_data(pm_data), .o_instr(instr), .o_file_rdata(rdata));
    cdt_decode_timing dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_instr(instr), .i_instr_valid(pm_valid),
        .i_file_rdata(rdata), .i_ptr_in_prog(ptr_prog), .o_fetch(o_fetch), .o_phase(o_phase),
        .o_dec(o_dec), .o_busy(o_busy), .o_file_rd(o_file_rd), .o_file_wr(o_file_wr),
        .o_acc_wr(o_acc_wr), .o_pc_redirect(o_pc_redirect), .o_extra_cycle(o_extra_cycle),
        .o_nop_cycle(o_nop_cycle), .o_cycles_used(o_cycles_used));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    // Seen bits: file_rd, file_wr, acc_wr, redirect, extra, nop
    task automatic exec(input logic [13:0] w, input logic [7:0] d, input logic [1:0] pp, input int n,
                        input logic [5:0] exp, input logic [5:0] mask);
        int clks;
        logic [5:0] seen;
        clks = 0;
        seen = 6'h00;
        @(posedge i_clk);
        pm_word <= w;
        pm_data <= d;
        ptr_prog <= pp;
        pm_valid <= 1'b1;
        @(negedge i_clk);
        check(o_busy === 1'b0, "busy with no word taken");
        while (o_fetch !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        pm_valid <= 1'b0;
        do begin
            @(negedge i_clk);
            clks++;
            seen |= {o_file_rd, o_file_wr, o_acc_wr, o_pc_redirect, o_extra_cycle, o_nop_cycle};
        end while (o_fetch !== 1'b1 && clks < 16);
        check(clks == n, "wrong clock count to next fetch");
        check((seen & mask) === (exp & mask), "wrong strobe set");
        check(o_phase === 2'h3, "fetch outside last phase");
        check(o_cycles_used === 2'(n / 4), "wrong instruction cycle count");
        check(o_busy === 1'b1, "not busy at end of instruction");
    endtask

    task automatic t_byte();
        exec(14'h07a5, 8'h3c, 2'b00, 4, 6'b110000, 6'b111111);
        check(o_dec.group === cdt_pkg::GRP_BYTE && o_dec.file_addr === 7'h25 && o_dec.dest === 1'b1, "byte");
        exec(14'h0725, 8'h3c, 2'b00, 4, 6'b101000, 6'b111111);
        exec(14'h00a5, 8'h3c, 2'b00, 4, 6'b110000, 6'b111111);
        exec(14'h07ff, 8'h3c, 2'b00, 4, 6'b110000, 6'b110111);
        check(o_dec.file_addr === 7'h7f, "top file address");
    endtask

    task automatic t_dont_care();
        exec(14'h0100, 8'h00, 2'b00, 4, 6'b001000, 6'b111111);
        saved = o_dec;
        exec(14'h0103, 8'h00, 2'b00, 4, 6'b001000, 6'b111111);
        check(o_dec.op === saved.op && o_dec.group === saved.group, "don't-care bits changed op");
        check(o_dec.writes_acc === saved.writes_acc && !o_dec.uses_file, "don't-care bits changed result");
    endtask

    task automatic t_control();
        logic [13:0] w [8] = '{14'h2123, 14'h000a, 14'h0008, 14'h3412, 14'h0009, 14'h2abc, 14'h3205, 14'h000b};
        foreach (w[i]) exec(w[i], 8'h00, 2'b00, 8, 6'b000101, 6'b000111);
        check(o_dec.group === cdt_pkg::GRP_LITCTL, "control group");
    endtask

    task automatic t_skip();
        exec(14'h1da0, 8'h08, 2'b00, 8, 6'b100101, 6'b100111);
        exec(14'h1da0, 8'hf7, 2'b00, 4, 6'b100000, 6'b100111);
        exec(14'h19a0, 8'hf7, 2'b00, 8, 6'b100101, 6'b100111);
        exec(14'h19a0, 8'h08, 2'b00, 4, 6'b100000, 6'b100111);
        exec(14'h0ba0, 8'h01, 2'b00, 8, 6'b100101, 6'b100111);
        exec(14'h0ba0, 8'h02, 2'b00, 4, 6'b100000, 6'b100111);
        exec(14'h0fa0, 8'hff, 2'b00, 8, 6'b100101, 6'b100111);
        exec(14'h0fa0, 8'hfe, 2'b00, 4, 6'b100000, 6'b100111);
    endtask

    task automatic t_indirect();
        exec(14'h0780, 8'h10, 2'b01, 8, 6'b110010, 6'b110111);
        exec(14'h0780, 8'h10, 2'b10, 4, 6'b110000, 6'b110111);
        exec(14'h0781, 8'h10, 2'b10, 8, 6'b110010, 6'b110111);
        exec(14'h0b80, 8'h01, 2'b01, 12, 6'b100111, 6'b100111);
    endtask

    // Reset in the idle second cycle of a call, then restart
    task automatic t_reset();
        @(posedge i_clk);
        pm_word <= 14'h2123;
        pm_valid <= 1'b1;
        @(negedge i_clk);
        while (o_fetch !== 1'b1) @(negedge i_clk);
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        check(o_nop_cycle === 1'b1 && o_cycles_used === 2'h2, "call second cycle");
        @(posedge i_clk);
        i_rstn <= 1'b0;
        pm_valid <= 1'b0;
        @(negedge i_clk);
        check(o_phase === 2'h0 && o_busy === 1'b0 && o_fetch === 1'b0, "reset state");
        check(o_dec === '0 && o_cycles_used === 2'h0 && o_nop_cycle === 1'b0, "reset clears decode");
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (2) @(negedge i_clk);
        check(o_phase === 2'h1 && o_busy === 1'b0, "phase after reset");
    endtask

    task automatic t_fields();
        exec(14'h16b3, 8'h00, 2'b00, 4, 6'b110000, 6'b110111);
        check(o_dec.group === cdt_pkg::GRP_BIT && o_dec.bit_pos === 3'h5 && o_dec.file_addr === 7'h33, "bit");
        exec(14'h2abc, 8'h00, 2'b00, 8, 6'b000101, 6'b000111);
        check(o_dec.lit === 11'h2bc, "literal target");
        exec(14'h3e12, 8'h00, 2'b00, 4, 6'b001000, 6'b111111);
        check(o_dec.lit[7:0] === 8'h12 && o_dec.group === cdt_pkg::GRP_LITCTL, "literal data");
        exec(14'h0025, 8'h00, 2'b00, 4, 6'b000000, 6'b111111);
        exec(14'h3180, 8'h00, 2'b00, 4, 6'b000000, 6'b111111);
        exec(14'h0064, 8'h00, 2'b00, 4, 6'b000000, 6'b111111);
        exec(14'h3585, 8'h00, 2'b00, 4, 6'b110000, 6'b111111);
        check(o_dec.group === cdt_pkg::GRP_BYTE && o_dec.file_addr === 7'h05, "shift in byte group");
        exec(14'h001e, 8'h00, 2'b10, 8, 6'b000010, 6'b000010);
        check(o_dec.ptr_num === 1'b1 && o_dec.ptr_mode === 2'h2, "pointer fields");
        for (int m = 0; m < 4; m++) begin
            exec(14'h0010 | 14'(m), 8'h00, 2'b10, 4, 6'b000000, 6'b000010);
            check(o_dec.ptr_mode === 2'(m) && o_dec.ptr_num === 1'b0, "pointer mode");
        end
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            $display("Error at %0t: timeout", $time);
            test_done();
        end
    end

    initial begin
        i_rstn = 1'b0;
        pm_valid = 1'b0;
        pm_word = 14'h0000;
        pm_data = 8'h00;
        ptr_prog = 2'b00;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_byte();
        t_dont_care();
        t_control();
        t_skip();
        t_reset();
        t_indirect();
        t_fields();
        test_done();
    end
endmodule
